// >>> logic/pdm_pkg.sv
// Shared constants and carrier types of the PLL divider and mux control block
package pdm_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFF_REFDIV = 8'h00;
   localparam logic [7:0] OFF_FB_A = 8'h04;
   localparam logic [7:0] OFF_FB_B = 8'h08;
   localparam logic [7:0] OFF_FB_C = 8'h0C;
   localparam logic [7:0] OFF_MUX = 8'h10;
   localparam logic [7:0] OFF_POST = 8'h14;
   localparam logic [7:0] OFF_PDEN = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;

   // ==========================================================
   // Field positions and reset value
   localparam int FB_C2_POS = 16;
   localparam int FB_W = 11;
   localparam int SWALLOW_W = 3;
   localparam int PDEN_POST_POS = 3;
   localparam logic [31:0] RST_VALUE = 32'h0000_0000;

   // ==========================================================
   // Divider constants
   localparam logic [3:0] PRESCALE_N = 4'h8;
   localparam logic [8:0] REF_ZERO_MOD = 9'h100;
   localparam int DIV_W = 9;

   // ==========================================================
   // Pin positions in the synchroniser vector
   localparam int PIN_XTAL = 0;
   localparam int PIN_ALT = 4;
   localparam int PIN_PD = 5;
   localparam int PIN_OE = 6;
   localparam int NPINS = 7;

   // ==========================================================
   // Mux source codes
   typedef enum logic [1:0] {
      PDM_SRC_REF = 2'h0,
      PDM_SRC_PLL_A = 2'h1,
      PDM_SRC_PLL_B = 2'h2,
      PDM_SRC_PLL_C = 2'h3
   } pdm_src_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [3:0][7:0] refdiv;
      logic [3:0][FB_W-1:0] fb;
      logic [5:0][1:0] mux;
      logic [5:0][3:0] post;
      logic [6:0] pden;
   } pdm_regs_t;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic [DIV_W-1:0] modulus;
      logic out;
   } pdm_div_state_t;

   typedef struct packed {
      logic [NPINS-1:0] s1;
      logic [NPINS-1:0] s2;
      logic [NPINS-1:0] s3;
      logic [NPINS-1:0] flt;
      pdm_regs_t r;
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic [2:0][3:0] pre;
      logic [2:0][2:0] acnt;
      logic [2:0][7:0] mcnt;
      logic [2:0][7:0] m_ld;
      logic [2:0][2:0] a_ld;
      logic [2:0] fb_pulse;
      logic [2:0] pll_pd;
      logic [3:0] oe;
      logic xin_low;
      logic crystal_output_high;
   } pdm_state_t;

endpackage

// >>> logic/pdm_divider.sv
// Programmable synchronous divider driven by source edge enables
`timescale 1ns/1ps
module pdm_divider #(
   parameter int W = 9
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   input wire logic tick,
   input wire logic src_level,
   input wire logic [W-1:0] modulus,
   output logic div_out
);

   pdm_pkg::pdm_div_state_t st;
   pdm_pkg::pdm_div_state_t next_st;

   // ==========================================================
   // Counter
   always_comb begin
      next_st = st;
      // A cleared modulus is never legal, so load at once after reset
      if (!run || st.modulus == '0) begin
         next_st.cnt = '0;
         next_st.modulus = modulus;
      end else if (tick) begin
         if (st.cnt >= st.modulus - W'(1)) begin
            // New modulus only at terminal count or while stopped: no torn period
            next_st.cnt = '0;
            next_st.modulus = modulus;
         end else begin
            next_st.cnt = st.cnt + W'(1);
         end
      end
      if (!run) begin
         next_st.out = 1'b0;
      end else if (next_st.modulus == W'(1)) begin
         next_st.out = src_level;
      end else begin
         next_st.out = next_st.cnt < (next_st.modulus >> 1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign div_out = st.out;

   // ==========================================================
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_div_stop_low: assert property (!run |=> !div_out)
      else $error("divider output not low while stopped");
   a_div_wrap: assert property (run && tick && st.cnt >= st.modulus - W'(1)
      |=> st.cnt == '0 && st.modulus == $past(modulus))
      else $error("divider did not wrap and reload at terminal count");

endmodule

// >>> logic/pdm_clock_ctrl.sv
// Three-PLL divider, output mux and power control with an AHB-Lite register slave
`timescale 1ns/1ps
module pdm_clock_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic crystal_ref,
   input wire logic [2:0] vco_clk,
   input wire logic alt_set_select,
   input wire logic power_down_request,
   input wire logic output_enable,
   output logic [2:0] pfd_ref,
   output logic [2:0] pfd_fb,
   output logic [2:0] pll_power_down,
   output logic [3:0] clk_out,
   output logic [3:0] clk_out_oe,
   output logic crystal_input_force_low,
   output logic crystal_output_pull_high
);

   pdm_pkg::pdm_state_t st;
   pdm_pkg::pdm_state_t next_st;

   logic [pdm_pkg::NPINS-1:0] pins;
   logic [3:0] rise;
   logic alt;
   logic [2:0] pll_off;
   logic [3:0] post_off;
   logic all_off;
   logic [3:0][7:0] ref_eff;
   logic [2:0][pdm_pkg::FB_W-1:0] fb_eff;
   logic [3:0][1:0] mux_eff;
   logic [3:0][3:0] post_eff;
   logic [2:0][pdm_pkg::DIV_W-1:0] ref_mod;
   logic [3:0][pdm_pkg::DIV_W-1:0] post_mod;
   logic [3:0] post_tick;
   logic [3:0] post_lvl;
   logic ap_valid;
   logic ap_mapped;

   assign pins = {output_enable, power_down_request, alt_set_select, vco_clk, crystal_ref};

   // ==========================================================
   // Decoded control from registered state
   always_comb begin
      // Rising edge once stages two and three agree high
      rise = st.s2[3:0] & st.s3[3:0] & ~st.flt[3:0];
      alt = st.flt[pdm_pkg::PIN_ALT];
      for (int i = 0; i < 3; i++) begin
         pll_off[i] = st.flt[pdm_pkg::PIN_PD] & st.r.pden[i];
      end
      for (int j = 0; j < 4; j++) begin
         post_off[j] = st.flt[pdm_pkg::PIN_PD] & st.r.pden[pdm_pkg::PDEN_POST_POS + j];
      end
      all_off = (&pll_off) & (&post_off);
      // Set one or set two for the C/D paths
      ref_eff[0] = st.r.refdiv[0];
      ref_eff[1] = st.r.refdiv[1];
      ref_eff[2] = alt ? st.r.refdiv[3] : st.r.refdiv[2];
      ref_eff[3] = 8'h00;
      fb_eff[0] = st.r.fb[0];
      fb_eff[1] = st.r.fb[1];
      fb_eff[2] = alt ? st.r.fb[3] : st.r.fb[2];
      mux_eff[0] = st.r.mux[0];
      mux_eff[1] = st.r.mux[1];
      mux_eff[2] = alt ? st.r.mux[4] : st.r.mux[2];
      mux_eff[3] = alt ? st.r.mux[5] : st.r.mux[3];
      post_eff[0] = st.r.post[0];
      post_eff[1] = st.r.post[1];
      post_eff[2] = alt ? st.r.post[4] : st.r.post[2];
      post_eff[3] = alt ? st.r.post[5] : st.r.post[3];
      for (int i = 0; i < 3; i++) begin
         ref_mod[i] = (ref_eff[i] == 8'h00) ? pdm_pkg::REF_ZERO_MOD
                                            : {1'b0, ref_eff[i]};
      end
      for (int j = 0; j < 4; j++) begin
         // Source code zero is the reference, so a cleared mux passes it through
         post_tick[j] = rise[mux_eff[j]];
         post_lvl[j] = st.flt[mux_eff[j]];
         post_mod[j] = {5'h00, post_eff[j]} + 9'h001;
      end
   end

   // ==========================================================
   // Bus decode
   assign ap_valid = hsel & htrans[1] & hready;
   assign ap_mapped = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0);

   // ==========================================================
   // Next state
   always_comb begin
      logic [3:0] pmod;
      logic [7:0] m_term;
      pmod = 4'h0;
      m_term = 8'h00;
      next_st = st;
      // Pin synchronisers: stage one feeds stage two only
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.flt = ((st.s2 ~^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.flt);
      // Writes land in the data phase, no wait for a later commit
      if (st.dp_wr) begin
         unique case (st.dp_addr)
            pdm_pkg::OFF_REFDIV: next_st.r.refdiv = hwdata;
            pdm_pkg::OFF_FB_A: next_st.r.fb[0] = hwdata[pdm_pkg::FB_W-1:0];
            pdm_pkg::OFF_FB_B: next_st.r.fb[1] = hwdata[pdm_pkg::FB_W-1:0];
            pdm_pkg::OFF_FB_C: begin
               next_st.r.fb[2] = hwdata[pdm_pkg::FB_W-1:0];
               next_st.r.fb[3] = hwdata[pdm_pkg::FB_C2_POS +: pdm_pkg::FB_W];
            end
            pdm_pkg::OFF_MUX: next_st.r.mux = hwdata[11:0];
            pdm_pkg::OFF_POST: next_st.r.post = hwdata[23:0];
            pdm_pkg::OFF_PDEN: next_st.r.pden = hwdata[6:0];
            default: ;
         endcase
      end
      next_st.dp_wr = ap_valid & hwrite & ap_mapped;
      next_st.dp_addr = haddr[7:0];
      next_st.hreadyout = 1'b1;
      // Read data from next values so a write just before is seen
      if (ap_valid && !hwrite) begin
         next_st.hrdata = pdm_pkg::RST_VALUE;
         if (ap_mapped) begin
            unique case (haddr[7:0])
               pdm_pkg::OFF_REFDIV: next_st.hrdata = next_st.r.refdiv;
               pdm_pkg::OFF_FB_A: next_st.hrdata = {21'h0, next_st.r.fb[0]};
               pdm_pkg::OFF_FB_B: next_st.hrdata = {21'h0, next_st.r.fb[1]};
               pdm_pkg::OFF_FB_C: next_st.hrdata = {5'h0, next_st.r.fb[3],
                                                    5'h0, next_st.r.fb[2]};
               pdm_pkg::OFF_MUX: next_st.hrdata = {20'h0, next_st.r.mux};
               pdm_pkg::OFF_POST: next_st.hrdata = {8'h0, next_st.r.post};
               pdm_pkg::OFF_PDEN: next_st.hrdata = {25'h0, next_st.r.pden};
               pdm_pkg::OFF_STATUS: next_st.hrdata = {16'h0, all_off, post_off,
                                                      pll_off, st.flt[6:4], 5'h0};
               default: next_st.hrdata = pdm_pkg::RST_VALUE;
            endcase
         end
      end
      // Dual-modulus feedback divider, one per PLL
      for (int i = 0; i < 3; i++) begin
         next_st.fb_pulse[i] = 1'b0;
         if (pll_off[i]) begin
            next_st.pre[i] = 4'h0;
            next_st.acnt[i] = 3'h0;
            next_st.mcnt[i] = 8'h00;
            next_st.m_ld[i] = fb_eff[i][pdm_pkg::FB_W-1:pdm_pkg::SWALLOW_W];
            next_st.a_ld[i] = fb_eff[i][pdm_pkg::SWALLOW_W-1:0];
         end else if (rise[i + 1]) begin
            // N+1 while swallowing, N after
            pmod = (st.acnt[i] < st.a_ld[i]) ? pdm_pkg::PRESCALE_N
                                             : pdm_pkg::PRESCALE_N - 4'h1;
            if (st.pre[i] >= pmod) begin
               next_st.pre[i] = 4'h0;
               if (st.acnt[i] < st.a_ld[i]) begin
                  next_st.acnt[i] = st.acnt[i] + 3'h1;
               end
               // Coarse count of zero behaves as one
               m_term = (st.m_ld[i] == 8'h00) ? 8'h00 : st.m_ld[i] - 8'h01;
               if (st.mcnt[i] >= m_term) begin
                  // Period is M*N+A; new word taken here or while the PLL is powered down
                  next_st.mcnt[i] = 8'h00;
                  next_st.acnt[i] = 3'h0;
                  next_st.fb_pulse[i] = 1'b1;
                  next_st.m_ld[i] = fb_eff[i][pdm_pkg::FB_W-1:pdm_pkg::SWALLOW_W];
                  next_st.a_ld[i] = fb_eff[i][pdm_pkg::SWALLOW_W-1:0];
               end else begin
                  next_st.mcnt[i] = st.mcnt[i] + 8'h01;
               end
            end else begin
               next_st.pre[i] = st.pre[i] + 4'h1;
            end
         end
      end
      // Pin-facing controls
      next_st.pll_pd = pll_off;
      next_st.oe = {4{st.flt[pdm_pkg::PIN_OE]}};
      next_st.xin_low = all_off;
      next_st.crystal_output_high = all_off;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Reference dividers, one per PLL
   for (genvar i = 0; i < 3; i++) begin : g_ref
      pdm_divider #(
         .W(pdm_pkg::DIV_W)
      ) u_ref_div (
         .hclk(hclk),
         .hresetn(hresetn),
         .run(~pll_off[i]),
         .tick(rise[pdm_pkg::PIN_XTAL]),
         .src_level(st.flt[pdm_pkg::PIN_XTAL]),
         .modulus(ref_mod[i]),
         .div_out(pfd_ref[i])
      );
   end

   // ==========================================================
   // Output paths: mux then post divider
   // Alternate select switches live; no glitch-free handover is attempted
   for (genvar j = 0; j < 4; j++) begin : g_post
      pdm_divider #(
         .W(pdm_pkg::DIV_W)
      ) u_post_div (
         .hclk(hclk),
         .hresetn(hresetn),
         .run(~post_off[j]),
         .tick(post_tick[j]),
         .src_level(post_lvl[j]),
         .modulus(post_mod[j]),
         .div_out(clk_out[j])
      );
   end

   // ==========================================================
   // Outputs
   assign hreadyout = st.hreadyout;
   assign hresp = 1'b0;
   assign hrdata = st.hrdata;
   assign pfd_fb = st.fb_pulse;
   assign pll_power_down = st.pll_pd;
   assign clk_out_oe = st.oe;
   assign crystal_input_force_low = st.xin_low;
   assign crystal_output_pull_high = st.crystal_output_high;

   // ==========================================================
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_ref_zero_mod: assert property (st.r.refdiv[0] == 8'h00 |-> ref_mod[0] == 9'h100)
      else $error("zero reference value not dividing by 256");
   a_oe_tristate: assert property (!st.flt[pdm_pkg::PIN_OE] |=> clk_out_oe == 4'h0)
      else $error("outputs enabled while output enable low");
   a_post_low: assert property (post_off[0] |=> !clk_out[0])
      else $error("powered-down path A not held low");
   a_osc_stop: assert property (all_off |=> crystal_input_force_low
      && crystal_output_pull_high)
      else $error("oscillator not stopped with everything down");
   a_pd_scope: assert property (!st.flt[pdm_pkg::PIN_PD] |=> pll_power_down == 3'h0)
      else $error("PLL powered down without power-down pin");
   a_write_apply: assert property (st.dp_wr && st.dp_addr == pdm_pkg::OFF_MUX
      |=> st.r.mux == $past(hwdata[11:0]))
      else $error("mux write not applied at data phase");
   a_alt_mux_c: assert property (alt |-> mux_eff[2] == st.r.mux[4]
      && post_eff[3] == st.r.post[5])
      else $error("alternate set not applied to paths C and D");
   a_fb_reload: assert property (!pll_off[0] && rise[1] && st.pre[0] >= 4'h7
      && st.acnt[0] >= st.a_ld[0] && st.mcnt[0] >= st.m_ld[0] - 8'h01
      |=> pfd_fb[0] && st.acnt[0] == 3'h0 && st.mcnt[0] == 8'h00)
      else $error("feedback cycle end did not pulse and reload");
   a_prescale_swallow: assert property (!pll_off[1] && rise[2] && st.acnt[1] < st.a_ld[1]
      && st.pre[1] == 4'h7 |=> st.pre[1] == 4'h8)
      else $error("prescaler did not stretch to N+1 while swallowing");
   a_bus_okay: assert property ($past(hresetn) |-> hreadyout && !hresp)
      else $error("slave answered with wait or error");

endmodule

// >>> testbench/pdm_clk_source.sv
// Crystal and VCO clock source model for the clock control block
`timescale 1ns/1ps
module pdm_clk_source (
   stop_ref,
   crystal_ref,
   vco_clk
);
   input wire logic stop_ref;
   output logic crystal_ref;
   output logic [2:0] vco_clk;

   // ==========================================================
   // Slow clocks, edges kept off the rising hclk edges
   initial begin
      crystal_ref = 1'b0;
      vco_clk = 3'h0;
   end
   // Stopped oscillator holds its input low
   always #200 crystal_ref = stop_ref ? 1'b0 : ~crystal_ref;
   always #150 vco_clk[0] = ~vco_clk[0];
   always #200 vco_clk[1] = ~vco_clk[1];
   always #250 vco_clk[2] = ~vco_clk[2];
endmodule

// >>> testbench/tb_pdm_clock_ctrl.sv
// Self-checking testbench of the PLL divider and mux control block
`timescale 1ns/1ps
module tb_pdm_clock_ctrl;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, crystal_ref, osc_low, osc_high;
   logic alt_set_select = 1'b0, power_down_request = 1'b0, output_enable = 1'b1;
   logic [2:0] vco_clk, pfd_ref, pfd_fb, pll_power_down;
   logic [3:0] clk_out, clk_out_oe;
   int error_cnt = 0, check_count = 0;

   pdm_clk_source src (.stop_ref(osc_low), .crystal_ref(crystal_ref), .vco_clk(vco_clk));

   pdm_clock_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .crystal_ref(crystal_ref), .vco_clk(vco_clk), .alt_set_select(alt_set_select),
      .power_down_request(power_down_request), .output_enable(output_enable),
      .pfd_ref(pfd_ref), .pfd_fb(pfd_fb), .pll_power_down(pll_power_down),
      .clk_out(clk_out), .clk_out_oe(clk_out_oe), .crystal_input_force_low(osc_low),
      .crystal_output_pull_high(osc_high));

   always #25 hclk = ~hclk;

   // ==========================================================
   // Checking and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // AHB-Lite master, one single word transfer per call
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) begin
         error_cnt++;
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wr ? d : 32'h0;
      wait_ready();
      rd = hrdata;
   endtask

   // ==========================================================
   // Period measurement on one clock or pulse output
   function automatic logic pick(input int s);
      return s < 4 ? clk_out[s] : (s < 7 ? pfd_ref[s-4] : pfd_fb[s-7]);
   endfunction

   // Skips the first period, so a modulus change has landed
   task automatic period_chk(input int s, input int exp);
      int n, k, g;
      logic p, c;
      n = 0;
      k = 0;
      g = 0;
      p = pick(s);
      while (k < 3 && g < 40000) begin
         @(posedge hclk);
         n++;
         g++;
         c = pick(s);
         if (c === 1'b1 && p === 1'b0) begin
            k++;
            if (k == 2) n = 0;
         end
         p = c;
      end
      check(n, exp);
   endtask

   // Outputs held low for a stretch while their path is off
   task automatic low_chk(input int s);
      logic seen;
      seen = 1'b0;
      repeat (40) begin
         @(posedge hclk);
         seen = seen | pick(s);
      end
      check(seen, 1'b0);
   endtask

   // ==========================================================
   // Watchdog
   initial begin
      repeat (95000) @(posedge hclk);
      error_cnt++;
      tally_and_finish();
   end

   // ==========================================================
   // Tests
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         ahb(1'b0, 8'(4 * i), 32'h0);
         check(rd, 32'h0);
      end
      period_chk(0, 8);
      ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h20, 32'h0);
      check(rd, 32'h0);
      // Register bits are loaded whole, in one data-phase write
      ahb(1'b1, pdm_pkg::OFF_REFDIV, 32'h0000_FF03);
      ahb(1'b0, pdm_pkg::OFF_REFDIV, 32'h0);
      check(rd, 32'h0000_FF03);
      period_chk(4, 24);
      period_chk(5, 2040);
      ahb(1'b1, pdm_pkg::OFF_REFDIV, 32'h0000_0003);
      period_chk(5, 2048);
      // Swallow count kept no larger than coarse count
      ahb(1'b1, pdm_pkg::OFF_FB_A, 32'h0000_0011);
      period_chk(7, 102);
      ahb(1'b1, pdm_pkg::OFF_FB_A, 32'h0000_0038);
      period_chk(7, 336);
      ahb(1'b1, pdm_pkg::OFF_FB_A, 32'h0000_07FF);
      period_chk(7, 12282);
      ahb(1'b1, pdm_pkg::OFF_FB_B, 32'h0000_0042);
      period_chk(8, 528);
      ahb(1'b1, pdm_pkg::OFF_MUX, 32'h0000_04E4);
      ahb(1'b1, pdm_pkg::OFF_POST, 32'h0040_0321);
      period_chk(0, 16);
      period_chk(1, 18);
      period_chk(2, 32);
      period_chk(3, 10);
      alt_set_select <= 1'b1;
      period_chk(2, 8);
      period_chk(3, 30);
      alt_set_select <= 1'b0;
      period_chk(2, 32);
      ahb(1'b1, pdm_pkg::OFF_PDEN, 32'h0000_0008);
      period_chk(0, 16);
      check(clk_out_oe, 4'hF);
      power_down_request <= 1'b1;
      repeat (10) @(posedge hclk);
      low_chk(0);
      period_chk(1, 18);
      check(osc_low, 1'b0);
      ahb(1'b1, pdm_pkg::OFF_PDEN, 32'h0000_0001);
      repeat (10) @(posedge hclk);
      check(pll_power_down, 3'h1);
      period_chk(0, 16);
      ahb(1'b1, pdm_pkg::OFF_PDEN, 32'h0000_007F);
      repeat (10) @(posedge hclk);
      check(pll_power_down, 3'h7);
      check({osc_low, osc_high}, 2'h3);
      low_chk(3);
      ahb(1'b0, pdm_pkg::OFF_STATUS, 32'h0);
      check(rd, 32'h0000_FFC0);
      power_down_request <= 1'b0;
      repeat (10) @(posedge hclk);
      check({osc_low, osc_high}, 2'h0);
      period_chk(1, 18);
      output_enable <= 1'b0;
      repeat (10) @(posedge hclk);
      check(clk_out_oe, 4'h0);
      output_enable <= 1'b1;
      repeat (10) @(posedge hclk);
      check(clk_out_oe, 4'hF);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, pdm_pkg::OFF_MUX, 32'h0);
      check(rd, 32'h0);
      tally_and_finish();
   end
endmodule
